//--- src/bcp_pkg.sv
// shared types and constants for the commutation and protection logic
// assumes analog comparators outside, each delivering a clean logic flag
//
// Overview of operation
// - hall pattern selects top and bottom switches
// - rotation monitor high on two-of-three hall
// - hall high above rise, low below fall
// - pwm from speed command versus ramp
// - chop bottoms only, tops stay on
// - overcurrent forces all bottoms off
// - overcurrent shutoff clears each oscillator period
// - undervoltage holds all six switches off
// - undervoltage released only above recovery level
// - overtemperature holds all six switches off
// - overtemperature released only below recovery temperature
// - command below ramp low stops bottoms
// - command below all-off level, all off
// - between levels tops follow, bottoms off
// - suppress bottom pulses shorter than minimum
package bcp_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLOCK_MHZ          = 125;
  localparam int unsigned MIN_PULSE_NS       = 800;
  localparam int unsigned MIN_PULSE_CYCLES   =
    (MIN_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CNT_W        = $clog2(MIN_PULSE_CYCLES + 1);

  // ==========================================================
  // reset values
  localparam logic        HALL_RESET_LEVEL   = 1'b0;
  localparam logic        FAULT_RESET_LEVEL  = 1'b0;
  localparam logic        GATE_OFF           = 1'b0;
  localparam logic        GATE_ON            = 1'b1;

  // ==========================================================
  // hall pattern codes, bit order u v w
  localparam logic [2:0]  HALL_UBOT_VTOP     = 3'h5;
  localparam logic [2:0]  HALL_UBOT_WTOP     = 3'h4;
  localparam logic [2:0]  HALL_VBOT_WTOP     = 3'h6;
  localparam logic [2:0]  HALL_UTOP_VBOT     = 3'h2;
  localparam logic [2:0]  HALL_UTOP_WBOT     = 3'h3;
  localparam logic [2:0]  HALL_VTOP_WBOT     = 3'h1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic u;
    logic v;
    logic w;
  } bcp_hall_t;

  typedef struct packed {
    logic top;
    logic bottom;
  } bcp_phase_t;

  typedef struct packed {
    bcp_phase_t u;
    bcp_phase_t v;
    bcp_phase_t w;
  } bcp_gate_t;

  typedef struct packed {
    logic above_ramp;
    logic above_ramp_low;
    logic above_all_off;
  } bcp_speed_t;

  typedef struct packed {
    logic undervoltage;
    logic overtemp;
    logic overcurrent;
  } bcp_fault_t;

  // ==========================================================
  // drive modes, one-hot
  typedef enum logic [3:0] {
    MODE_ALL_OFF  = 4'h1,
    MODE_TOP_ONLY = 4'h2,
    MODE_DRIVE    = 4'h4,
    MODE_FAULT    = 4'h8
  } bcp_mode_t;

endpackage

//--- src/bcp_min_pulse.sv
// minimum pulse width filter for one gate line
// assumes input synchronous to clock; output is a flip-flop
module bcp_min_pulse
  import bcp_pkg::*;
(
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic gate_req,
  output logic      gate_out
);

  logic [PULSE_CNT_W-1:0] cnt_q;
  logic [PULSE_CNT_W-1:0] cnt_d;
  logic                   out_q;
  logic                   out_d;
  wire logic              width_met;

  // ==========================================================
  // width measure
  // count high time
  assign width_met = (cnt_q == PULSE_CNT_W'(MIN_PULSE_CYCLES - 1));

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!gate_req) begin
      // turn-off is immediate, protection must never wait
      cnt_d = '0;
      out_d = GATE_OFF;
    end else if (width_met) begin
      out_d = GATE_ON;
    end else begin
      cnt_d = cnt_q + PULSE_CNT_W'(1);
    end
  end

  // ==========================================================
  // state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      out_q <= GATE_OFF;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign gate_out = out_q;

endmodule

//--- src/bcp_top.sv
// commutation, pwm and protection logic of a three-phase motor driver
// assumes comparator flags already synchronous; analog parts are outside
module bcp_top (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire bcp_pkg::bcp_hall_t hall_rise_flags,
  input  wire bcp_pkg::bcp_hall_t hall_fall_flags,
  input  wire bcp_pkg::bcp_speed_t speed_command_input,
  input  wire logic               current_sense_input,
  input  wire logic               oscillator_clock_pin,
  input  wire logic               undervoltage_trip_level,
  input  wire logic               undervoltage_recover_level,
  input  wire logic               overtemp_trip_level,
  input  wire logic               overtemp_recover_level,
  output bcp_pkg::bcp_phase_t     phase_u_output,
  output bcp_pkg::bcp_phase_t     phase_v_output,
  output bcp_pkg::bcp_phase_t     phase_w_output,
  output logic                    rotation_monitor_out,
  output bcp_pkg::bcp_fault_t     fault_status,
  output bcp_pkg::bcp_mode_t      drive_mode
);
  import bcp_pkg::*;

  // ==========================================================
  // declarations
  bcp_hall_t  hall_q;
  bcp_hall_t  hall_d;
  logic       fg_q;
  wire logic  fg_d;
  logic       uv_q;
  logic       uv_d;
  logic       ot_q;
  logic       ot_d;
  logic       oc_q;
  logic       oc_d;
  logic       osc_prev_q;
  wire logic  osc_rise;
  bcp_mode_t  mode_q;
  bcp_mode_t  mode_d;
  bcp_gate_t  pattern;
  wire logic  top_u_g;
  wire logic  top_v_g;
  wire logic  top_w_g;
  wire logic  bot_u_g;
  wire logic  bot_v_g;
  wire logic  bot_w_g;
  wire logic  bot_enable;
  wire logic  zone_off;
  wire logic  zone_top;
  logic       top_u_q;
  logic       top_v_q;
  logic       top_w_q;
  wire logic  bot_u_f;
  wire logic  bot_v_f;
  wire logic  bot_w_f;
  wire logic  all_off_fault;
  wire logic  tops_allowed;
  wire logic  bottoms_allowed;
  wire logic  pwm_on;
  wire logic  [2:0] hall_code;

  // ==========================================================
  // hall level hysteresis
  // set above rise threshold
  always_comb begin
    hall_d = hall_q;
    if (hall_rise_flags.u) begin
      hall_d.u = 1'b1;
    end else if (hall_fall_flags.u) begin
      hall_d.u = 1'b0;
    end
    if (hall_rise_flags.v) begin
      hall_d.v = 1'b1;
    end else if (hall_fall_flags.v) begin
      hall_d.v = 1'b0;
    end
    if (hall_rise_flags.w) begin
      hall_d.w = 1'b1;
    end else if (hall_fall_flags.w) begin
      hall_d.w = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // levels start at 000 so no switch moves before the sensors settle
      hall_q <= '{HALL_RESET_LEVEL, HALL_RESET_LEVEL, HALL_RESET_LEVEL};
    end else begin
      hall_q <= hall_d;
    end
  end

  assign hall_code = {hall_q.u, hall_q.v, hall_q.w};

  // ==========================================================
  // rotation monitor
  // majority of three levels
  assign fg_d = (hall_q.u & hall_q.v) | (hall_q.u & hall_q.w) |
                (hall_q.v & hall_q.w);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fg_q <= 1'b0;
    end else begin
      fg_q <= fg_d;
    end
  end

  // ==========================================================
  // commutation table
  // pattern to switch pairs
  always_comb begin
    pattern = '0;
    case (hall_code)
      HALL_UBOT_VTOP: begin
        pattern.u.bottom = GATE_ON;
        pattern.v.top    = GATE_ON;
      end
      HALL_UBOT_WTOP: begin
        pattern.u.bottom = GATE_ON;
        pattern.w.top    = GATE_ON;
      end
      HALL_VBOT_WTOP: begin
        pattern.v.bottom = GATE_ON;
        pattern.w.top    = GATE_ON;
      end
      HALL_UTOP_VBOT: begin
        pattern.u.top    = GATE_ON;
        pattern.v.bottom = GATE_ON;
      end
      HALL_UTOP_WBOT: begin
        pattern.u.top    = GATE_ON;
        pattern.w.bottom = GATE_ON;
      end
      HALL_VTOP_WBOT: begin
        pattern.v.top    = GATE_ON;
        pattern.w.bottom = GATE_ON;
      end
      // invalid 000 and 111 leave everything off
      default: begin
        pattern = '0;
      end
    endcase
  end

  // ==========================================================
  // supply and temperature latches
  // trip holds all off
  always_comb begin
    uv_d = uv_q;
    if (undervoltage_trip_level) begin
      uv_d = 1'b1;
    end else if (undervoltage_recover_level) begin
      uv_d = 1'b0;
    end
  end

  always_comb begin
    ot_d = ot_q;
    if (overtemp_trip_level) begin
      ot_d = 1'b1;
    end else if (overtemp_recover_level) begin
      ot_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uv_q <= FAULT_RESET_LEVEL;
      ot_q <= FAULT_RESET_LEVEL;
    end else begin
      uv_q <= uv_d;
      ot_q <= ot_d;
    end
  end

  // ==========================================================
  // overcurrent latch
  // the oscillator pin is sampled as a plain level, only its rise matters
  assign osc_rise = oscillator_clock_pin & ~osc_prev_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= oscillator_clock_pin;
    end
  end

  always_comb begin
    oc_d = oc_q;
    if (current_sense_input) begin
      // set wins over the periodic release
      oc_d = 1'b1;
    end else if (osc_rise) begin
      oc_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oc_q <= FAULT_RESET_LEVEL;
    end else begin
      oc_q <= oc_d;
    end
  end

  // ==========================================================
  // speed zones and drive mode
  // undervoltage and overtemperature or-ed together
  assign all_off_fault = uv_d | ot_d;
  assign zone_off      = !speed_command_input.above_all_off;
  assign zone_top      = !speed_command_input.above_ramp_low;

  always_comb begin
    mode_d = MODE_ALL_OFF;
    if (all_off_fault) begin
      mode_d = MODE_FAULT;
    end else if (zone_off) begin
      mode_d = MODE_ALL_OFF;
    end else if (zone_top) begin
      mode_d = MODE_TOP_ONLY;
    end else begin
      mode_d = MODE_DRIVE;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_ALL_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // mode is decoded from live flags so a trip never waits a cycle
  assign tops_allowed    = (mode_d == MODE_TOP_ONLY) || (mode_d == MODE_DRIVE);
  assign bottoms_allowed = (mode_d == MODE_DRIVE);
  assign pwm_on          = speed_command_input.above_ramp;

  // ==========================================================
  // gating
  // chop bottoms only
  assign bot_enable = bottoms_allowed & pwm_on & ~oc_d;
  assign top_u_g    = pattern.u.top & tops_allowed;
  assign top_v_g    = pattern.v.top & tops_allowed;
  assign top_w_g    = pattern.w.top & tops_allowed;
  assign bot_u_g    = pattern.u.bottom & bot_enable;
  assign bot_v_g    = pattern.v.bottom & bot_enable;
  assign bot_w_g    = pattern.w.bottom & bot_enable;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      top_u_q <= GATE_OFF;
      top_v_q <= GATE_OFF;
      top_w_q <= GATE_OFF;
    end else begin
      top_u_q <= top_u_g;
      top_v_q <= top_v_g;
      top_w_q <= top_w_g;
    end
  end

  // ==========================================================
  // bottom pulse filters
  // drop short bottom pulses
  bcp_min_pulse u_filt_u (
    .clock    (clock),
    .arst_n   (arst_n),
    .gate_req (bot_u_g),
    .gate_out (bot_u_f)
  );

  bcp_min_pulse u_filt_v (
    .clock    (clock),
    .arst_n   (arst_n),
    .gate_req (bot_v_g),
    .gate_out (bot_v_f)
  );

  bcp_min_pulse u_filt_w (
    .clock    (clock),
    .arst_n   (arst_n),
    .gate_req (bot_w_g),
    .gate_out (bot_w_f)
  );

  // ==========================================================
  // outputs, all from flip-flops
  assign phase_u_output       = '{top_u_q, bot_u_f};
  assign phase_v_output       = '{top_v_q, bot_v_f};
  assign phase_w_output       = '{top_w_q, bot_w_f};
  assign rotation_monitor_out = fg_q;
  assign fault_status         = '{uv_q, ot_q, oc_q};
  assign drive_mode           = mode_q;

endmodule

//--- bench/bcp_top_props.sv
// checker of the commutation and protection logic
// assumes a bind onto every bcp_top instance
module bcp_top_props
  import bcp_pkg::*;
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire bcp_hall_t  hall_rise_flags,
  input wire bcp_hall_t  hall_fall_flags,
  input wire bcp_speed_t speed_command_input,
  input wire logic       current_sense_input,
  input wire logic       undervoltage_trip_level,
  input wire logic       undervoltage_recover_level,
  input wire logic       overtemp_trip_level,
  input wire logic       overtemp_recover_level,
  input wire bcp_phase_t phase_u_output,
  input wire bcp_phase_t phase_v_output,
  input wire bcp_phase_t phase_w_output,
  input wire logic       rotation_monitor_out,
  input wire bcp_fault_t fault_status,
  input wire bcp_mode_t  drive_mode
);
  wire logic [5:0] gates = {phase_u_output, phase_v_output, phase_w_output};
  wire logic       quiet = speed_command_input.above_all_off && !undervoltage_trip_level
                           && !overtemp_trip_level && fault_status[2:1] == 2'h0;
  // run of cycles in which a bottom request could have stood high
  wire logic       run_ok = speed_command_input == 3'h7 && !current_sense_input
                            && !undervoltage_trip_level && !overtemp_trip_level;
  logic [7:0]      run_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 8'h00;
    end else if (!run_ok) begin
      run_q <= 8'h00;
    end else if (run_q != 8'hff) begin
      run_q <= run_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ======
  // gate, rotation monitor and fault latch checks
  chk_uv_all_off:
    assert property (undervoltage_trip_level |=> gates == 6'h0)
    else $error("gate on in undervoltage");
  chk_ot_all_off:
    assert property (overtemp_trip_level |=> gates == 6'h0)
    else $error("gate on in overtemperature");
  chk_oc_bottoms_off:
    assert property (current_sense_input |=> (gates & 6'h15) == 6'h0)
    else $error("bottom on in overcurrent");
  chk_speed_all_off:
    assert property (!speed_command_input.above_all_off |=> gates == 6'h0)
    else $error("gate on below all-off level");
  chk_stop_bottoms:
    assert property (!speed_command_input.above_ramp_low |=> (gates & 6'h15) == 6'h0)
    else $error("bottom on below ramp low");
  chk_short_pwm:
    assert property ($rose(phase_u_output.bottom) || $rose(phase_v_output.bottom)
      || $rose(phase_w_output.bottom) |-> run_q >= 8'(MIN_PULSE_CYCLES))
    else $error("short pwm pulse passed");
  chk_top_pattern:
    assert property ((hall_rise_flags == 3'h5 && hall_fall_flags == 3'h2)[*2] ##0 quiet
      |=> (gates & 6'h2a) == 6'h08)
    else $error("wrong top for pattern 101");
  chk_rot_majority:
    assert property ((hall_rise_flags == 3'h7)[*2] |=> rotation_monitor_out)
    else $error("rotation monitor low on 111");
  chk_uv_latch_hold:
    assert property (undervoltage_trip_level || (fault_status.undervoltage
      && !undervoltage_recover_level) |=> fault_status.undervoltage)
    else $error("undervoltage released early");
  chk_ot_latch_hold:
    assert property (overtemp_trip_level || (fault_status.overtemp
      && !overtemp_recover_level) |=> fault_status.overtemp)
    else $error("overtemperature released early");

  cover property ($rose(phase_u_output.bottom));
  cover property (fault_status.overcurrent ##1 !fault_status.overcurrent);
  cover property (drive_mode == MODE_TOP_ONLY);
endmodule

bind bcp_top bcp_top_props u_props (
  .clock                      (clock),
  .arst_n                     (arst_n),
  .hall_rise_flags            (hall_rise_flags),
  .hall_fall_flags            (hall_fall_flags),
  .speed_command_input        (speed_command_input),
  .current_sense_input        (current_sense_input),
  .undervoltage_trip_level    (undervoltage_trip_level),
  .undervoltage_recover_level (undervoltage_recover_level),
  .overtemp_trip_level        (overtemp_trip_level),
  .overtemp_recover_level     (overtemp_recover_level),
  .phase_u_output             (phase_u_output),
  .phase_v_output             (phase_v_output),
  .phase_w_output             (phase_w_output),
  .rotation_monitor_out       (rotation_monitor_out),
  .fault_status               (fault_status),
  .drive_mode                 (drive_mode)
);

//--- bench/bcp_hall_model.sv
// three hall sensors with their comparators
// assumes the bench picks the code after a rising edge
module bcp_hall_model
  import bcp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [2:0] hall_code,
  input  wire logic       in_band,
  output bcp_hall_t       rise_flags,
  output bcp_hall_t       fall_flags
);
  always_ff @(posedge clock) begin
    rise_flags <= in_band ? 3'h0 : hall_code;
    fall_flags <= in_band ? 3'h0 : ~hall_code;
  end
endmodule

//--- bench/tb_bldc_commutation_protection.sv
// self-checking bench of the commutation and protection logic
// assumes bcp_top, its bound checker and the hall model
module tb_bldc_commutation_protection;
  timeunit 1ns;
  timeprecision 1ps;
  import bcp_pkg::*;

  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] hall_code = 3'h0;
  logic       in_band = 1'b0;
  bcp_hall_t  rise_flags;
  bcp_hall_t  fall_flags;
  bcp_speed_t speed = 3'h7;
  logic       sense = 1'b0;
  logic       osc = 1'b0;
  logic       uv_trip = 1'b0;
  logic       uv_ok = 1'b1;
  logic       ot_trip = 1'b0;
  logic       ot_ok = 1'b1;
  bcp_phase_t pu;
  bcp_phase_t pv;
  bcp_phase_t pw;
  logic       rot;
  bcp_fault_t fault;
  bcp_mode_t  mode;
  int         error_cnt = 0;
  int         num_checks = 0;
  wire logic [5:0] gates = {pu, pv, pw};

  always #4 clock = ~clock;

  bcp_hall_model u_hall (.clock(clock), .hall_code(hall_code), .in_band(in_band),
    .rise_flags(rise_flags), .fall_flags(fall_flags));

  bcp_top uut (.clock(clock), .arst_n(arst_n), .hall_rise_flags(rise_flags),
    .hall_fall_flags(fall_flags), .speed_command_input(speed),
    .current_sense_input(sense), .oscillator_clock_pin(osc),
    .undervoltage_trip_level(uv_trip), .undervoltage_recover_level(uv_ok),
    .overtemp_trip_level(ot_trip), .overtemp_recover_level(ot_ok),
    .phase_u_output(pu), .phase_v_output(pv), .phase_w_output(pw),
    .rotation_monitor_out(rot), .fault_status(fault), .drive_mode(mode));

  // ======
  // helpers
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // gates u.top u.bot v.top v.bot w.top w.bot
  function automatic logic [5:0] pat(logic [2:0] c);
    case (c)
      3'h5: pat = 6'h18;
      3'h4: pat = 6'h12;
      3'h6: pat = 6'h06;
      3'h2: pat = 6'h24;
      3'h3: pat = 6'h21;
      3'h1: pat = 6'h09;
      default: pat = 6'h00;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ======
  // scenarios
  task automatic t_reset();
    wt(3);
    chk("rst_gates", 8'(gates), 8'h0);
    chk("rst_mode", 8'(mode), 8'h1);
    chk("rst_status", 8'({rot, fault}), 8'h0);
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    $display("reset done");
  endtask

  task automatic t_commute();
    for (int c = 0; c < 8; c++) begin
      @(posedge clock) hall_code <= 3'(c);
      wt(110);
      chk("gates", 8'(gates), 8'(pat(3'(c))));
      chk("rot", 8'(rot), 8'($countones(3'(c)) >= 2));
    end
    $display("commute done");
  endtask

  // code moves inside the band and must be ignored
  task automatic t_band();
    @(posedge clock) hall_code <= 3'h5;
    wt(110);
    @(posedge clock) in_band <= 1'b1;
    @(posedge clock) hall_code <= 3'h2;
    wt(10);
    chk("band", 8'(gates), 8'h18);
    @(posedge clock) in_band <= 1'b0;
    wt(110);
    chk("band_exit", 8'(gates), 8'h24);
    $display("band done");
  endtask

  task automatic t_pwm();
    logic [5:0] seen_b = 6'h0;
    logic [5:0] top_lo = 6'h0;
    @(posedge clock) speed.above_ramp <= 1'b0;
    wt(4);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock) speed.above_ramp <= (i % 80) >= 40;
      #1;
      seen_b |= gates & 6'h15;
      top_lo |= ~gates & 6'h20;
    end
    chk("short_pulse", 8'(seen_b), 8'h0);
    chk("top_steady", 8'(top_lo), 8'h0);
    @(posedge clock) speed.above_ramp <= 1'b1;
    wt(110);
    chk("pwm_on", 8'(gates), 8'h24);
    $display("pwm done");
  endtask

  task automatic t_oc();
    @(posedge clock) sense <= 1'b1;
    @(posedge clock) sense <= 1'b0;
    wt(2);
    chk("oc_gates", 8'(gates), 8'h20);
    chk("oc_flag", 8'(fault), 8'h1);
    wt(20);
    chk("oc_held", 8'(gates), 8'h20);
    @(posedge clock) osc <= 1'b1;
    wt(3);
    chk("oc_clr", 8'(fault), 8'h0);
    wt(110);
    chk("oc_back", 8'(gates), 8'h24);
    @(posedge clock) osc <= 1'b0;
    $display("overcurrent done");
  endtask

  task automatic t_prot(logic ot);
    @(posedge clock) begin
      uv_trip <= !ot;
      ot_trip <= ot;
      uv_ok <= 1'b0;
      ot_ok <= 1'b0;
    end
    wt(3);
    chk("prot_gates", 8'(gates), 8'h0);
    chk("prot_flag", 8'(fault), ot ? 8'h2 : 8'h4);
    chk("prot_mode", 8'(mode), 8'h8);
    @(posedge clock) begin
      uv_trip <= 1'b0;
      ot_trip <= 1'b0;
    end
    wt(10);
    chk("prot_hold", 8'(gates), 8'h0);
    @(posedge clock) begin
      uv_ok <= 1'b1;
      ot_ok <= 1'b1;
    end
    wt(110);
    chk("prot_back", 8'(gates), 8'h24);
    $display("protection done");
  endtask

  task automatic t_speed();
    @(posedge clock) speed <= 3'h1;
    wt(4);
    chk("top_only", 8'(gates), 8'h20);
    chk("mode_top", 8'(mode), 8'h2);
    @(posedge clock) speed <= 3'h0;
    wt(4);
    chk("all_off", 8'(gates), 8'h0);
    chk("mode_off", 8'(mode), 8'h1);
    @(posedge clock) speed <= 3'h7;
    wt(110);
    chk("drive", 8'(gates), 8'h24);
    chk("mode_drive", 8'(mode), 8'h4);
    $display("speed done");
  endtask

  initial begin
    t_reset();
    t_commute();
    t_band();
    t_pwm();
    t_oc();
    t_prot(1'b0);
    t_prot(1'b1);
    t_speed();
    print_verdict();
  end

  // run should end near 17 us
  initial begin
    #40000;
    error_cnt++;
    $display("[ERR] watchdog expected end seen hang");
    print_verdict();
  end
endmodule
